/* File: lac_host_model.sv */
// ****************************************
// host bus master driving the register port
// ****************************************
module lac_host_model
  import lac_pkg::*;
(
  input wire logic clk,
  output logic [6:0] busDevAddr, // address of the current transfer
  output logic [7:0] regAddr, // register offset
  output logic regWrEn, // one-cycle write strobe
  output logic [7:0] regWrData,
  output logic regRdEn, // one-cycle read strobe
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idles with strobes low from time zero
  initial begin
    busDevAddr = LAC_SLAVE_ADDR;
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // write: strobe held for exactly the edge that takes it
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
    @(posedge clk);
    busDevAddr <= dev;
    regAddr <= ofs;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  // read: data is registered, so sample one edge after the take
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d);
    @(posedge clk);
    busDevAddr <= dev;
    regAddr <= ofs;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    #1;
    d = regRdData;
  endtask : rd
endmodule : lac_host_model

/* File: lac_light_adc.sv */
module lac_light_adc
  import lac_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [6:0] busDevAddr, // device address of the current transfer
  input wire logic [7:0] regAddr, // register offset
  input wire logic regWrEn, // one-cycle write strobe
  input wire logic [7:0] regWrData,
  input wire logic regRdEn, // one-cycle read strobe
  output logic [7:0] regRdData, // valid the cycle after regRdEn
  input wire logic lightPulse, // photocurrent pulse train, asynchronous
  output logic adcActive, // front end powered
  output logic irSelect, // front end senses infrared
  output logic [1:0] spanIndex, // full_scale_span index minus one
  output logic intPinOut, // open-drain pin level when driven
  output logic intPinOeN // low while pulling the pin low
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] cmdReg; // mode, flag, persistence
  logic [7:0] resRange; // resolution_range_config
  logic [15:0] result; // last conversion
  logic [15:0] lowThr; // lower threshold
  logic [15:0] highThr; // upper threshold
  logic addrHit; // transfer is for this device
  logic wrHit; // write to this device
  logic cmdXfer; // transfer of command register completes
  logic convDone; // one-cycle end of conversion
  logic trigger; // persistence reached this conversion

  assign addrHit = (busDevAddr == LAC_SLAVE_ADDR);
  assign wrHit = regWrEn && addrHit;
  assign cmdXfer = (regWrEn || regRdEn) && addrHit && (regAddr == LAC_OFS_CMD);

  // command register: writable fields, flag set by hardware
  always_ff @(posedge clk) begin
    if (srst) begin
      cmdReg <= LAC_RST_CMD;
    end else begin
      if (wrHit && regAddr == LAC_OFS_CMD) begin
        cmdReg[7:5] <= regWrData[7:5];
        cmdReg[1:0] <= regWrData[1:0];
      end
      // set wins over the transfer clear
      if (trigger) begin
        cmdReg[LAC_CMD_FLAG_BIT] <= 1'b1;
      end else if (cmdXfer) begin
        cmdReg[LAC_CMD_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // config and threshold registers; result offsets take no writes
  always_ff @(posedge clk) begin
    if (srst) begin
      resRange <= LAC_RST_RESRANGE;
      lowThr <= {LAC_RST_LT, LAC_RST_LT};
      highThr <= {LAC_RST_HT, LAC_RST_HT};
    end else if (wrHit) begin
      case (regAddr)
        LAC_OFS_RESRANGE: resRange <= regWrData & LAC_RESRANGE_MASK;
        LAC_OFS_LT_LO: lowThr[7:0] <= regWrData;
        LAC_OFS_LT_HI: lowThr[15:8] <= regWrData;
        LAC_OFS_HT_LO: highThr[7:0] <= regWrData;
        LAC_OFS_HT_HI: highThr[15:8] <= regWrData;
        default: ; // result and unmapped offsets ignored
      endcase
    end
  end

  // read data, registered
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (regRdEn && addrHit) begin
      case (regAddr)
        LAC_OFS_CMD: regRdData <= cmdReg & (LAC_CMD_WR_MASK | 8'h04);
        LAC_OFS_RESRANGE: regRdData <= resRange;
        LAC_OFS_RES_LO: regRdData <= result[7:0];
        LAC_OFS_RES_HI: regRdData <= result[15:8];
        LAC_OFS_LT_LO: regRdData <= lowThr[7:0];
        LAC_OFS_LT_HI: regRdData <= lowThr[15:8];
        LAC_OFS_HT_LO: regRdData <= highThr[7:0];
        LAC_OFS_HT_HI: regRdData <= highThr[15:8];
        default: regRdData <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  // ****************************************
  // mode decode and front-end controls
  // ****************************************
  logic modeRun; // continuous conversion selected

  assign modeRun = (cmdReg[7:5] == LAC_MODE_VIS) || (cmdReg[7:5] == LAC_MODE_IR);

  // front-end steering from registers
  always_ff @(posedge clk) begin
    if (srst) begin
      adcActive <= 1'b0;
      irSelect <= 1'b0;
      spanIndex <= 2'h0;
    end else begin
      adcActive <= modeRun;
      irSelect <= (cmdReg[7:5] == LAC_MODE_IR);
      spanIndex <= resRange[1:0];
    end
  end

  // ****************************************
  // integration
  // ****************************************
  logic oscTick; // oscillator period pulse
  logic [2:0] pulseSync; // two synchroniser stages plus edge history
  logic pulseEdge; // rising edge of synchronised pulse
  logic [16:0] oscCnt; // oscillator cycles elapsed
  logic [16:0] countAcc; // photocurrent count
  logic [16:0] cyclesSel; // cycles for chosen resolution
  lac_state_t state;

  lac_osc_div u_osc (
    .clk(clk),
    .srst(srst),
    .run(state == LAC_INTEG),
    .tick(oscTick)
  );

  assign cyclesSel = lac_cycles(resRange[3:2]);
  assign pulseEdge = pulseSync[1] && !pulseSync[2];
  assign convDone = (state == LAC_DONE);

  // synchroniser for the asynchronous pulse input
  always_ff @(posedge clk) begin
    if (srst) begin
      pulseSync <= 3'h0;
    end else begin
      pulseSync <= {pulseSync[1:0], lightPulse};
    end
  end

  // conversion sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= LAC_IDLE;
      oscCnt <= 17'h00000;
      countAcc <= 17'h00000;
    end else begin
      case (state)
        LAC_IDLE: begin
          oscCnt <= 17'h00000;
          countAcc <= 17'h00000;
          if (modeRun) begin
            state <= LAC_INTEG;
          end
        end
        LAC_INTEG: begin
          if (!modeRun) begin
            state <= LAC_IDLE;
          end else if (oscCnt >= cyclesSel) begin
            state <= LAC_DONE;
          end
          if (oscTick) begin
            oscCnt <= oscCnt + 17'h00001;
          end
          // count saturates at the code ceiling, also after a lower resolution is written
          if (countAcc >= cyclesSel) begin
            countAcc <= cyclesSel - 17'h00001;
          end else if (pulseEdge && countAcc < cyclesSel - 17'h00001) begin
            countAcc <= countAcc + 17'h00001;
          end
        end
        LAC_DONE: begin
          state <= LAC_IDLE;
        end
        default: state <= LAC_IDLE;
      endcase
    end
  end

  // result capture at conversion end
  always_ff @(posedge clk) begin
    if (srst) begin
      result <= {LAC_RST_RESULT, LAC_RST_RESULT};
    end else if (convDone) begin
      result <= countAcc[15:0];
    end
  end

  // ****************************************
  // threshold window and persistence
  // ****************************************
  logic outWindow; // result out of window
  logic [4:0] persistCnt; // consecutive out-of-window conversions

  assign outWindow = (countAcc[15:0] < lowThr) || (countAcc[15:0] > highThr);
  assign trigger = convDone && outWindow && (persistCnt + 5'h01 >= lac_persist(cmdReg[1:0]));

  // consecutive count, reset by any in-window result
  always_ff @(posedge clk) begin
    if (srst) begin
      persistCnt <= 5'h00;
    end else if (convDone) begin
      if (!outWindow) begin
        persistCnt <= 5'h00;
      end else if (persistCnt != 5'h10) begin
        persistCnt <= persistCnt + 5'h01;
      end
    end
  end

  // open-drain pin follows the flag
  always_ff @(posedge clk) begin
    if (srst) begin
      intPinOut <= 1'b0;
      intPinOeN <= 1'b1;
    end else begin
      intPinOut <= 1'b0;
      intPinOeN <= !cmdReg[LAC_CMD_FLAG_BIT];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_conv_end;
    convDone;
  endsequence

  a_result_refresh: assert property (@(posedge clk) disable iff (srst)
    s_conv_end |=> result == $past(countAcc[15:0]))
    else $error("result not refreshed at conversion end");
  a_flag_clear: assert property (@(posedge clk) disable iff (srst)
    cmdXfer && !trigger |=> !cmdReg[LAC_CMD_FLAG_BIT])
    else $error("flag not cleared by command transfer");
  a_flag_set: assert property (@(posedge clk) disable iff (srst)
    trigger |=> cmdReg[LAC_CMD_FLAG_BIT] ##1 !intPinOeN)
    else $error("flag or pin missed a trigger");
  a_persist_one: assert property (@(posedge clk) disable iff (srst)
    s_conv_end and outWindow && cmdReg[1:0] == 2'h0 |-> trigger)
    else $error("single out-of-window result ignored at m=1");
  a_nibble_zero: assert property (@(posedge clk) disable iff (srst)
    resRange[7:4] == 4'h0)
    else $error("config upper nibble not zero");
  a_addr_filter: assert property (@(posedge clk) disable iff (srst)
    regWrEn && !addrHit |=> $stable(lowThr) && $stable(highThr) && $stable(resRange))
    else $error("write taken at foreign address");
  a_powerdown_idle: assert property (@(posedge clk) disable iff (srst)
    !modeRun [*2] |-> !convDone)
    else $error("conversion while powered down");
  a_result_width: assert property (@(posedge clk) disable iff (srst)
    s_conv_end |-> countAcc < cyclesSel)
    else $error("result exceeds resolution");

endmodule : lac_light_adc

/* File: lac_osc_div.sv */
// ****************************************
// internal oscillator stand-in
// ****************************************
module lac_osc_div
  import lac_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic run, // oscillator runs while converting
  output logic tick // one-cycle pulse per oscillator period
);

  logic [15:0] divCnt; // clock cycles within one period

  // period counter, held at zero while stopped
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      divCnt <= 16'h0000;
      tick <= 1'b0;
    end else if (divCnt == 16'(LAC_OSC_DIV - 1)) begin
      divCnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      divCnt <= divCnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // a tick is followed by at least two cycles without a tick
  a_tick_spacing: assert property (@(posedge clk) disable iff (srst || !run)
    tick |=> !tick [*2])
    else $error("oscillator ticks too close");

endmodule : lac_osc_div

/* File: lac_pkg.sv */
// Function
// - resolution field sets cycles per conversion
// - integration lasts the selected oscillator cycles
// - range field selects full-scale span index
// - result low byte 02, high 03
// - result right-aligned to selected resolution
// - both result bytes overwritten each conversion
// - lower threshold at 04/05, reset 00
// - upper threshold at 06/07, reset ff
// - integration is 2^n oscillator periods
// - interrupt after m consecutive out-of-window results
// - mode field: off, visible, infrared, reserved
// - command register transfer clears flag and pin
// - answer only at fixed address 1000100
package lac_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] LAC_OFS_CMD = 8'h00; // mode, flag, persistence
  localparam logic [7:0] LAC_OFS_RESRANGE = 8'h01; // resolution_range_config
  localparam logic [7:0] LAC_OFS_RES_LO = 8'h02; // result_low_byte
  localparam logic [7:0] LAC_OFS_RES_HI = 8'h03; // result_high_byte
  localparam logic [7:0] LAC_OFS_LT_LO = 8'h04; // lower_threshold_low_byte
  localparam logic [7:0] LAC_OFS_LT_HI = 8'h05; // lower_threshold_high_byte
  localparam logic [7:0] LAC_OFS_HT_LO = 8'h06; // upper_threshold_low_byte
  localparam logic [7:0] LAC_OFS_HT_HI = 8'h07; // upper_threshold_high_byte

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [7:0] LAC_RST_CMD = 8'h00;
  localparam logic [7:0] LAC_RST_RESRANGE = 8'h00;
  localparam logic [7:0] LAC_RST_LT = 8'h00;
  localparam logic [7:0] LAC_RST_HT = 8'hff;
  localparam logic [7:0] LAC_RST_RESULT = 8'h00;
  localparam int LAC_CMD_MODE_LSB = 5; // mode field bits 7:5
  localparam int LAC_CMD_FLAG_BIT = 2; // interrupt flag
  localparam logic [7:0] LAC_CMD_WR_MASK = 8'he3; // mode and persistence writable
  localparam logic [7:0] LAC_RESRANGE_MASK = 8'h0f; // upper nibble reads zero
  localparam logic [6:0] LAC_SLAVE_ADDR = 7'h44; // 1000100

  // operating modes
  localparam logic [2:0] LAC_MODE_OFF = 3'h0;
  localparam logic [2:0] LAC_MODE_VIS = 3'h5;
  localparam logic [2:0] LAC_MODE_IR = 3'h6;

  // ****************************************
  // timing
  // ****************************************
  localparam longint LAC_CLK_HZ = 250_000_000; // system clock rate
  localparam longint LAC_OSC_HZ = 655_000; // internal_osc_frequency, nominal resistor
  // nominal period rounds down to whole clock cycles
  localparam int LAC_OSC_DIV = int'(LAC_CLK_HZ / LAC_OSC_HZ);

  // integration-state machine
  typedef enum logic [1:0] {LAC_IDLE, LAC_INTEG, LAC_DONE} lac_state_t;

  // oscillator cycles per conversion from resolution code
  function automatic logic [16:0] lac_cycles(input logic [1:0] res);
    case (res)
      2'h0: lac_cycles = 17'h10000; // 65,536
      2'h1: lac_cycles = 17'h01000; // 4,096
      2'h2: lac_cycles = 17'h00100; // 256
      default: lac_cycles = 17'h00010; // 16
    endcase
  endfunction : lac_cycles

  // persistence code to integration count m
  function automatic logic [4:0] lac_persist(input logic [1:0] code);
    case (code)
      2'h0: lac_persist = 5'h01;
      2'h1: lac_persist = 5'h04;
      2'h2: lac_persist = 5'h08;
      default: lac_persist = 5'h10;
    endcase
  endfunction : lac_persist

endpackage : lac_pkg

/* File: light_adc_config_readout_tb.sv */
// ****************************************
// self-checking bench for the light converter
// ****************************************
module light_adc_config_readout_tb
  import lac_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CONV = 16 * 381; // clocks per 4-bit conversion
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic lightPulse = 1'b0; // photocurrent stand-in
  logic lightOn = 1'b0; // enables the pulse train
  logic [6:0] busDevAddr;
  logic [7:0] regAddr;
  logic regWrEn;
  logic [7:0] regWrData;
  logic regRdEn;
  logic [7:0] regRdData;
  logic adcActive;
  logic irSelect;
  logic [1:0] spanIndex;
  logic intPinOut;
  logic intPinOeN;
  logic [7:0] mdl [0:7]; // reference register file
  logic [7:0] rv; // last value read
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0; // run length for the hang guard

  // free-running 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // hang guard, then the pulse train with an edge every 8 clocks
  always @(posedge clk) begin
    cycles <= cycles + 1;
    lightPulse <= lightOn & cycles[2];
    if (cycles == 50000) begin
      fail_count++;
      wrap_up();
    end
  end

  lac_host_model host (.clk(clk), .busDevAddr(busDevAddr), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

  lac_light_adc DUT (.clk(clk), .srst(srst), .busDevAddr(busDevAddr), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .lightPulse(lightPulse), .adcActive(adcActive), .irSelect(irSelect),
    .spanIndex(spanIndex), .intPinOut(intPinOut), .intPinOeN(intPinOeN));

  // ****************************************
  // helper tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // write through the bus and mirror the writable bits
  task automatic mwr(input logic [7:0] ofs, input logic [7:0] d);
    host.wr(LAC_SLAVE_ADDR, ofs, d);
    case (ofs)
      8'h00: mdl[0] = d & 8'he3;
      8'h01: mdl[1] = d & 8'h0f;
      8'h04, 8'h05, 8'h06, 8'h07: mdl[ofs[2:0]] = d;
      default: ; // result and unmapped places keep their value
    endcase
  endtask : mwr

  // read and compare, unmapped offsets read zero
  task automatic mrd(input logic [7:0] ofs, input string what);
    host.rd(LAC_SLAVE_ADDR, ofs, rv);
    check(what, rv, (ofs < 8'h08) ? mdl[ofs[2:0]] : 8'h00);
  endtask : mrd

  // wait whole cycles and step past the edge
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hfdec));
    mdl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // reset contents plus one unmapped offset
    for (int i = 0; i < 9; i++) mrd(i[7:0], "reset value");
    // result bytes ignore writes, foreign address ignored
    mwr(LAC_OFS_RES_LO, 8'h5a);
    mwr(LAC_OFS_RES_HI, 8'ha5);
    host.wr(7'h45, LAC_OFS_LT_LO, 8'h77);
    mrd(LAC_OFS_RES_LO, "result low");
    mrd(LAC_OFS_RES_HI, "result high");
    mrd(LAC_OFS_LT_LO, "foreign write");
    // thresholds take random bytes
    for (int i = 4; i < 8; i++) begin
      mwr(i[7:0], 8'($urandom));
      mrd(i[7:0], "threshold");
    end
    // every mode code
    for (int i = 0; i < 8; i++) begin
      mwr(LAC_OFS_CMD, 8'(i << 5));
      idle(2);
      check("adcActive", adcActive, 8'(i == 5 || i == 6));
      check("irSelect", irSelect, 8'(i == 6));
    end
    // every range code with random resolution and upper bits
    for (int i = 0; i < 4; i++) begin
      mwr(LAC_OFS_RESRANGE, (8'($urandom) & 8'hfc) | 8'(i));
      idle(2);
      check("spanIndex", spanIndex, 8'(i));
      mrd(LAC_OFS_RESRANGE, "config");
    end
    // dark input below a lower threshold of one, persistence 1
    mwr(LAC_OFS_CMD, 8'h00);
    mwr(LAC_OFS_LT_LO, 8'h01);
    mwr(LAC_OFS_LT_HI, 8'h00);
    mwr(LAC_OFS_HT_LO, 8'hff);
    mwr(LAC_OFS_HT_HI, 8'hff);
    mwr(LAC_OFS_RESRANGE, 8'h0c);
    mwr(LAC_OFS_CMD, 8'ha0);
    idle(2 * CONV + 800);
    mrd(LAC_OFS_RES_LO, "dark low");
    mrd(LAC_OFS_RES_HI, "dark high");
    check("intPinOeN", intPinOeN, 8'h00);
    check("intPinOut", intPinOut, 8'h00);
    host.rd(LAC_SLAVE_ADDR, LAC_OFS_CMD, rv);
    check("flag set", rv, mdl[0] | 8'h04);
    idle(2);
    check("intPinOeN", intPinOeN, 8'h01);
    // reset again mid-run: conversion stops, persistence count and registers cleared
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    mdl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
    mrd(LAC_OFS_HT_HI, "reset again");
    mrd(LAC_OFS_RESRANGE, "config reset");
    check("adcActive", adcActive, 8'h00);
    // bright input above an upper threshold of 14, persistence 4
    mwr(LAC_OFS_CMD, 8'h00);
    mwr(LAC_OFS_RESRANGE, 8'h0c);
    mwr(LAC_OFS_LT_LO, 8'h00);
    mwr(LAC_OFS_HT_LO, 8'h0e);
    mwr(LAC_OFS_HT_HI, 8'h00);
    lightOn <= 1'b1;
    mwr(LAC_OFS_CMD, 8'hc1);
    idle(CONV - 500);
    mrd(LAC_OFS_RES_LO, "early result");
    idle(CONV + 900);
    mdl[2] = 8'h0f;
    mrd(LAC_OFS_RES_LO, "bright low");
    mrd(LAC_OFS_RES_HI, "bright high");
    mrd(LAC_OFS_CMD, "flag early");
    check("intPinOeN", intPinOeN, 8'h01);
    idle(2 * CONV + 200);
    check("intPinOeN", intPinOeN, 8'h00);
    wrap_up();
  end
endmodule : light_adc_config_readout_tb
